/* File: wake_detect_pkg.sv */
// Purpose: Shared constants and carriers for the wake-frame detector
// Assumes: Core clock 20 MHz; registers are 16 bits in 32-bit AHB words
// Notes: Register byte address is four times the register index
package wake_detect_pkg;

   // Register indices; byte address = index * 4
   localparam logic [11:0] IDX_CFG = 12'h04A0;
   localparam logic [11:0] IDX_STAT = 12'h04A1;
   localparam logic [11:0] IDX_DA45 = 12'h04A2;
   localparam logic [11:0] IDX_DA23 = 12'h04A3;
   localparam logic [11:0] IDX_DA01 = 12'h04A4;
   localparam logic [11:0] IDX_PW01 = 12'h04A5;
   localparam logic [11:0] IDX_PW23 = 12'h04A6;
   localparam logic [11:0] IDX_PW45 = 12'h04A7;

   // Configuration field positions
   localparam int CFG_ORDER_LO = 14;
   localparam int CFG_SFD_SEL = 13;
   localparam int CFG_CRC_GATE = 12;
   localparam int CFG_LVL_CLR = 11;
   localparam int CFG_PW_LO = 9;
   localparam int CFG_IND_LVL = 8;
   localparam int CFG_EN = 7;
   localparam int CFG_PWD_EN = 5;
   localparam int CFG_PAT_EN = 1;
   localparam int CFG_MP_EN = 0;
   localparam logic [15:0] CFG_RST = 16'h1000;

   // Status field positions
   localparam int ST_INT_SRC = 12;
   localparam int ST_SFD_ERR = 7;
   localparam int ST_BAD_CRC = 6;
   localparam int ST_HACK = 5;
   localparam int ST_PAT = 1;
   localparam int ST_MAGIC = 0;

   // Frame constants
   localparam logic [7:0] SFD_NORMAL = 8'hD5;
   localparam logic [7:0] SFD_ALT = 8'h5D;
   localparam logic [7:0] SYNC_BYTE = 8'hFF;
   localparam int SYNC_LEN = 6;
   localparam int ADDR_COPIES = 16;
   localparam int ADDR_LEN = 6;
   localparam int PWD_LEN = 6;

   // Pulse widths: printed in cycles of a 100 MHz clock, rounded up here
   localparam int REF_CLK_MHZ = 100;
   localparam int CORE_CLK_MHZ = 20;
   localparam int PULSE_REF_CYC = 8;
   localparam int PULSE_CYC0 = (PULSE_REF_CYC * CORE_CLK_MHZ + REF_CLK_MHZ - 1) / REF_CLK_MHZ;
   localparam int PULSE_CYC1 = (2 * PULSE_REF_CYC * CORE_CLK_MHZ + REF_CLK_MHZ - 1) / REF_CLK_MHZ;
   localparam int PULSE_CYC2 = (4 * PULSE_REF_CYC * CORE_CLK_MHZ + REF_CLK_MHZ - 1) / REF_CLK_MHZ;
   localparam int PULSE_CYC3 = (8 * PULSE_REF_CYC * CORE_CLK_MHZ + REF_CLK_MHZ - 1) / REF_CLK_MHZ;

   // One received byte from the datapath
   typedef struct packed {
      logic valid;
      logic sof;
      logic eof;
      logic crc_bad;
      logic [7:0] data;
   } rx_beat_t;

endpackage

/* File: wake_detect.sv */
// Purpose: Wake-frame detector with its AHB-Lite register bank
// Assumes: Receive bytes and pattern hits come from logic on i_core_clk
// Notes: Zero-wait slave; status flags clear when the status word is read
// Function
// R1: Ordering field rearranges received bytes: normal, bit reverse, nibble swap, nibble-bit reverse.
// R2: Delimiter select bit chooses searched delimiter 0x5D when set, else 0xD5.
// R3: CRC gate set suppresses magic and pattern indications on bad CRC frames.
// R4: With CRC gate cleared, a bad CRC gives no indication at all.
// R5: In level mode, writing the clear bit drops the held wake level.
// R6: Pulse width field selects 8, 16, 32 or 64 reference cycles.
// R7: Indication select bit picks held level (1) or pulse (0).
// R8: Wake detection runs only while the enable bit is set.
// R9: Password enable requires matching password after the magic packet; the code also counts a frame ending on the last address byte as a match.
// R10: Pattern enable raises the wake event on pattern frames.
// R11: Magic enable raises the wake event on valid magic packets.
// R12: Source select routes wake event or polarity event to interrupt bit.
// R13: Enabling wake detection sets the interrupt source select to wake.
// R14: Missing selected delimiter sets a latched delimiter-error flag.
// R15: Bad CRC frame sets a latched bad-CRC flag.
// R16: Wrong magic-packet password sets a latched intrusion flag.
// R17: Valid frame containing pattern sets a latched pattern flag.
// R18: Valid magic packet sets a latched magic flag.
// R19: Destination bytes 4 and 5 sit in register 0x04A2, reset zero.
// R20: Configuration register sits at 0x04A0.
// R21: Destination bytes 2,3 at 0x04A3 and 0,1 at 0x04A4.
// R22: Six password bytes live in three read-write registers, reset zero.
// R23: Latched flags hold until the status read, which returns then clears them.
// R24: Magic packet is six 0xFF bytes then sixteen destination address copies.
`timescale 1ns/100ps
module wake_detect (
   // Clock, reset, enable
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   input wire logic i_clk_en,
   // AHB-Lite slave
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic [31:0] o_hrdata,
   // Receive side
   input wake_detect_pkg::rx_beat_t i_rx,
   input wire logic i_pattern_hit,
   input wire logic i_pol_event,
   // Indications
   output logic o_wake,
   output logic o_int_event
);
   import wake_detect_pkg::*;

   typedef enum logic [2:0] {
      P_IDLE = 3'b000,
      P_SEARCH = 3'b001,
      P_ADDR = 3'b010,
      P_PWD = 3'b011,
      P_DROP = 3'b100
   } parse_t;

   typedef struct packed {
      logic [15:0] cfg;
      logic int_src;
      logic [7:0] flags;
      logic [2:0][15:0] da;
      logic [2:0][15:0] pw;
      logic dp_wr;
      logic [11:0] dp_idx;
      logic [31:0] rdata;
      parse_t ps;
      logic [2:0] sync_cnt;
      logic [6:0] byte_idx;
      logic magic_seen;
      logic pwd_ok;
      logic pat_seen;
      logic wake_lvl;
      logic [7:0] pulse_cnt;
      logic wake_out;
      logic int_evt;
   } state_t;

   state_t r;
   state_t n;

   // Byte reordering ahead of detection
   function automatic logic [7:0] reorder(input logic [7:0] d, input logic [1:0] m);
      logic [7:0] o;
      o = d;
      unique case (m)
         2'b00: o = d;
         2'b01: o = {d[0], d[1], d[2], d[3], d[4], d[5], d[6], d[7]};
         2'b10: o = {d[3:0], d[7:4]};
         2'b11: o = {d[4], d[5], d[6], d[7], d[0], d[1], d[2], d[3]};
      endcase
      return o;
   endfunction

   // Address byte k as it arrives on the wire, byte 0 first
   function automatic logic [7:0] addr_byte(input logic [2:0][15:0] da, input logic [2:0] k);
      logic [7:0] o;
      o = 8'h00;
      unique case (k)
         3'd0: o = da[2][15:8];
         3'd1: o = da[2][7:0];
         3'd2: o = da[1][15:8];
         3'd3: o = da[1][7:0];
         3'd4: o = da[0][15:8];
         3'd5: o = da[0][7:0];
         default: o = 8'h00;
      endcase
      return o;
   endfunction

   // Password byte k, byte 0 first, even byte in the low half
   function automatic logic [7:0] pwd_byte(input logic [2:0][15:0] pw, input logic [2:0] k);
      logic [7:0] o;
      o = 8'h00;
      unique case (k)
         3'd0: o = pw[0][7:0];
         3'd1: o = pw[0][15:8];
         3'd2: o = pw[1][7:0];
         3'd3: o = pw[1][15:8];
         3'd4: o = pw[2][7:0];
         3'd5: o = pw[2][15:8];
         default: o = 8'h00;
      endcase
      return o;
   endfunction

   // Read value of a register; status flags use the pre-clear value
   function automatic logic [15:0] read_reg(input state_t s, input logic [11:0] idx);
      logic [15:0] v;
      v = 16'h0000;
      case (idx)
         IDX_CFG: v = s.cfg & ~(16'h0001 << CFG_LVL_CLR);
         IDX_STAT: v = {3'b000, s.int_src, 4'h0, s.flags};
         IDX_DA45: v = s.da[0];
         IDX_DA23: v = s.da[1];
         IDX_DA01: v = s.da[2];
         IDX_PW01: v = s.pw[0];
         IDX_PW23: v = s.pw[1];
         IDX_PW45: v = s.pw[2];
         default: v = 16'h0000;
      endcase
      return v;
   endfunction

   logic addr_ok;
   logic [11:0] addr_idx;
   logic [7:0] rx_byte;
   logic [7:0] sfd_want;
   logic [7:0] set_flags;
   logic [7:0] clr_flags;
   logic ev_wake;
   logic gate_bad;
   logic magic_ok;
   logic pat_ok;
   logic pwd_hit;
   logic lvl_clr;
   logic [7:0] pulse_len;

   // Bus address decode; word index from bits 13:2, and bits 31:14 must be zero for a read or write to hit
   assign addr_idx = i_haddr[13:2];
   assign addr_ok = i_hsel & i_htrans[1] & i_hready;

   // Reordered data and selected delimiter
   assign rx_byte = reorder(i_rx.data, r.cfg[CFG_ORDER_LO +: 2]); // [R1]
   assign sfd_want = r.cfg[CFG_SFD_SEL] ? SFD_ALT : SFD_NORMAL; // [R2]

   // Pulse length from the width field
   always_comb begin
      pulse_len = 8'(PULSE_CYC0);
      unique case (r.cfg[CFG_PW_LO +: 2]) // [R6]
         2'b00: pulse_len = 8'(PULSE_CYC0);
         2'b01: pulse_len = 8'(PULSE_CYC1);
         2'b10: pulse_len = 8'(PULSE_CYC2);
         2'b11: pulse_len = 8'(PULSE_CYC3);
      endcase
   end

   // Whole next-state computation; a low clock enable holds everything
   always_comb begin
      n = r;
      set_flags = 8'h00;
      clr_flags = 8'h00;
      ev_wake = 1'b0;
      gate_bad = 1'b0;
      magic_ok = 1'b0;
      pat_ok = 1'b0;
      pwd_hit = 1'b0;
      lvl_clr = 1'b0;
      if (i_clk_en) begin
         // Data phase write
         if (r.dp_wr) begin
            case (r.dp_idx)
               IDX_CFG: begin
                  n.cfg = i_hwdata[15:0] & ~(16'h0001 << CFG_LVL_CLR); // [R20]
                  lvl_clr = i_hwdata[CFG_LVL_CLR]; // [R5]
                  if (i_hwdata[CFG_EN] && !r.cfg[CFG_EN]) begin
                     n.int_src = 1'b1; // [R13]
                  end
               end
               IDX_STAT: n.int_src = i_hwdata[ST_INT_SRC];
               IDX_DA45: n.da[0] = i_hwdata[15:0]; // [R19]
               IDX_DA23: n.da[1] = i_hwdata[15:0]; // [R21]
               IDX_DA01: n.da[2] = i_hwdata[15:0]; // [R21]
               IDX_PW01: n.pw[0] = i_hwdata[15:0]; // [R22]
               IDX_PW23: n.pw[1] = i_hwdata[15:0]; // [R22]
               IDX_PW45: n.pw[2] = i_hwdata[15:0]; // [R22]
               default: n.int_src = n.int_src;
            endcase
            if (r.dp_idx == IDX_CFG && i_hwdata[CFG_EN] && !r.cfg[CFG_EN]) begin
               n.int_src = 1'b1; // [R13]
            end
         end
         // Address phase: capture read data, so a write just before is seen
         n.dp_wr = 1'b0;
         if (addr_ok) begin
            n.dp_wr = i_hwrite & (i_haddr[31:14] == 18'h0_0000);
            n.dp_idx = addr_idx;
            if (!i_hwrite) begin
               n.rdata = 32'h0000_0000;
               if (i_haddr[31:14] == 18'h0_0000) begin
                  n.rdata = {16'h0000, read_reg(n, addr_idx)};
                  if (addr_idx == IDX_STAT) begin
                     clr_flags = r.flags; // [R23]
                  end
               end
            end
         end
         // Frame parser, active only while detection is enabled
         if (!r.cfg[CFG_EN]) begin
            n.ps = P_IDLE; // [R8]
         end else if (i_rx.valid) begin
            if (i_rx.sof) begin
               n.sync_cnt = 3'd0;
               n.byte_idx = 7'd0;
               n.magic_seen = 1'b0;
               n.pwd_ok = 1'b0;
               n.pat_seen = 1'b0;
               if (rx_byte == sfd_want) begin
                  n.ps = P_SEARCH;
               end else begin
                  n.ps = P_DROP;
                  set_flags[ST_SFD_ERR] = 1'b1; // [R14]
               end
            end else begin
               unique case (r.ps)
                  P_IDLE: n.ps = P_IDLE;
                  P_DROP: n.ps = P_DROP;
                  P_SEARCH: begin
                     // Six sync bytes, then first address byte [R24]
                     if (rx_byte == SYNC_BYTE) begin
                        if (r.sync_cnt != 3'(SYNC_LEN)) begin
                           n.sync_cnt = r.sync_cnt + 3'd1;
                        end
                     end else if (r.sync_cnt == 3'(SYNC_LEN) && rx_byte == addr_byte(r.da, 3'd0)) begin
                        n.ps = P_ADDR;
                        n.byte_idx = 7'd1;
                     end else begin
                        n.sync_cnt = 3'd0;
                     end
                  end
                  P_ADDR: begin
                     // Sixteen address copies, compared byte by byte [R24]
                     if (rx_byte == addr_byte(r.da, 3'(r.byte_idx % 7'(ADDR_LEN)))) begin
                        n.byte_idx = r.byte_idx + 7'd1;
                        if (r.byte_idx == 7'(ADDR_COPIES * ADDR_LEN - 1)) begin
                           n.magic_seen = 1'b1;
                           n.byte_idx = 7'd0;
                           n.pwd_ok = 1'b1;
                           n.ps = r.cfg[CFG_PWD_EN] ? P_PWD : P_DROP; // [R9]
                        end
                     end else begin
                        n.ps = P_SEARCH;
                        n.sync_cnt = (rx_byte == SYNC_BYTE) ? 3'd1 : 3'd0;
                     end
                  end
                  P_PWD: begin
                     // Password follows the last address copy [R9]
                     if (rx_byte != pwd_byte(r.pw, 3'(r.byte_idx))) begin
                        n.pwd_ok = 1'b0;
                     end
                     n.byte_idx = r.byte_idx + 7'd1;
                     if (r.byte_idx == 7'(PWD_LEN - 1)) begin
                        n.ps = P_DROP;
                     end
                  end
               endcase
            end
            if (i_pattern_hit && n.ps != P_IDLE) begin
               n.pat_seen = 1'b1;
            end
            // Frame end: judge the frame
            if (i_rx.eof && n.ps != P_IDLE) begin
               n.ps = P_IDLE;
               // Bad CRC reported and gating only while the gate is on [R3] [R4]
               gate_bad = r.cfg[CFG_CRC_GATE] & i_rx.crc_bad;
               set_flags[ST_BAD_CRC] = gate_bad; // [R15]
               // A password cut short after 1 to 5 bytes is a mismatch; a frame ending on the last address byte matches
               pwd_hit = n.pwd_ok & (r.ps != P_PWD || r.byte_idx == 7'(PWD_LEN - 1));
               magic_ok = n.magic_seen & (~r.cfg[CFG_PWD_EN] | pwd_hit) & ~gate_bad; // [R3]
               pat_ok = n.pat_seen & ~gate_bad; // [R3]
               set_flags[ST_HACK] = n.magic_seen & r.cfg[CFG_PWD_EN] & ~pwd_hit; // [R16]
               set_flags[ST_PAT] = pat_ok; // [R17]
               set_flags[ST_MAGIC] = magic_ok; // [R18]
               ev_wake = (magic_ok & r.cfg[CFG_MP_EN]) // [R11]
                  | (pat_ok & r.cfg[CFG_PAT_EN]); // [R10]
            end
         end
         // Flags: an event in the clearing cycle still lands
         n.flags = (r.flags & ~clr_flags) | set_flags; // [R23]
         // Wake indication, level or pulse
         if (r.cfg[CFG_IND_LVL]) begin // [R7]
            n.pulse_cnt = 8'd0;
            if (ev_wake) begin
               n.wake_lvl = 1'b1;
            end else if (lvl_clr) begin
               n.wake_lvl = 1'b0; // [R5]
            end
         end else begin
            n.wake_lvl = 1'b0;
            if (ev_wake) begin
               n.pulse_cnt = pulse_len; // [R6]
            end else if (r.pulse_cnt != 8'd0) begin
               n.pulse_cnt = r.pulse_cnt - 8'd1;
            end
         end
         n.wake_out = n.wake_lvl | (n.pulse_cnt != 8'd0);
         // Shared interrupt bit source
         n.int_evt = r.int_src ? ev_wake : i_pol_event; // [R12]
      end
   end

   // State register
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         r <= '0;
         r.cfg <= CFG_RST; // [R3]
      end else begin
         r <= n;
      end
   end

   // Outputs; zero-wait, always OKAY
   assign o_hreadyout = 1'b1;
   assign o_hresp = 1'b0;
   assign o_hrdata = r.rdata;
   assign o_wake = r.wake_out;
   assign o_int_event = r.int_evt;

endmodule

/* File: wake_detect_monitor.sv */
// Purpose: Port-level checker for the wake-frame detector
// Assumes: One slave, word transfers; config and source shadowed from bus writes
// Notes: Shadow tracks the auto-set of the source bit when detection is enabled
`timescale 1ns/100ps
module wake_detect_monitor (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   input wire logic i_clk_en,
   // Bus
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   input wire logic [31:0] o_hrdata,
   // Events
   input wire logic i_pol_event,
   input wire logic o_wake,
   input wire logic o_int_event
);
   import wake_detect_pkg::*;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_b);
   logic [15:0] cfg_r;
   logic [7:0] wcnt_r;
   logic [7:0] wexp_r;
   logic src_r, wr_r, cfg_hit_r, st_hit_r, clr_d_r, acc, cfg_wr, clr_now;
   int wexp;
   // Decoded bus phases; clear is seen in the data phase
   assign acc = i_hsel & i_htrans[1] & i_hready & i_clk_en;
   assign cfg_wr = wr_r & cfg_hit_r & i_clk_en;
   assign clr_now = cfg_wr & i_hwdata[CFG_LVL_CLR];
   assign wexp = cfg_r[10] ? (cfg_r[9] ? PULSE_CYC3 : PULSE_CYC2)
                           : (cfg_r[9] ? PULSE_CYC1 : PULSE_CYC0);
   // Shadow registers and wake length counter
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cfg_r <= CFG_RST;
         src_r <= 1'b0;
         wr_r <= 1'b0;
         cfg_hit_r <= 1'b0;
         st_hit_r <= 1'b0;
         clr_d_r <= 1'b0;
         wcnt_r <= 8'h00;
         wexp_r <= 8'h00;
      end else begin
         // Width frozen at pulse start; a config write during the pulse must not move it
         if (!o_wake)
            wexp_r <= 8'(wexp);
         wr_r <= acc & i_hwrite;
         cfg_hit_r <= i_haddr[13:2] == IDX_CFG;
         st_hit_r <= i_haddr[13:2] == IDX_STAT;
         clr_d_r <= clr_now;
         wcnt_r <= o_wake ? wcnt_r + 8'h01 : 8'h00;
         if (cfg_wr)
            cfg_r <= {i_hwdata[15:12], 1'b0, i_hwdata[10:0]};
         if (cfg_wr & i_hwdata[CFG_EN] & !cfg_r[CFG_EN])
            src_r <= 1'b1;
         else if (wr_r & st_hit_r & i_clk_en)
            src_r <= i_hwdata[ST_INT_SRC];
      end
   end
   a_pulse_width: assert property ($fell(o_wake) && !cfg_r[CFG_IND_LVL] |-> wcnt_r == wexp_r)
      else $error("wake pulse width wrong");
   a_level_hold: assert property (o_wake && cfg_r[CFG_IND_LVL] && !clr_now && !clr_d_r |=> o_wake)
      else $error("held wake level dropped");
   a_level_clear: assert property (clr_now && cfg_r[CFG_IND_LVL] |-> ##[1:2] !o_wake)
      else $error("wake level not cleared");
   a_wake_enabled: assert property ($rose(o_wake) |-> cfg_r[CFG_EN])
      else $error("wake while detection disabled");
   a_int_on_wake: assert property ($rose(o_wake) && src_r |-> o_int_event)
      else $error("wake not routed to interrupt");
   a_int_single: assert property (o_int_event |=> !o_int_event)
      else $error("interrupt event longer than one cycle");
   a_pol_route: assert property (i_pol_event && !src_r |-> ##[1:2] o_int_event)
      else $error("polarity event not routed");
   a_cfg_read: assert property (acc && !i_hwrite && i_haddr[13:2] == IDX_CFG && !cfg_wr
      |=> o_hrdata == {16'h0000, cfg_r})
      else $error("config read back wrong");
   c_pulse: cover property ($fell(o_wake) && !cfg_r[CFG_IND_LVL]);
   c_clear: cover property (clr_now && o_wake);
   c_pol: cover property (i_pol_event && !src_r);
endmodule
bind wake_detect wake_detect_monitor mon (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
   .i_clk_en(i_clk_en), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
   .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready), .o_hrdata(o_hrdata),
   .i_pol_event(i_pol_event), .o_wake(o_wake), .o_int_event(o_int_event));

/* File: rx_station.sv */
// Purpose: Remote station model playing received frames into the detector
// Assumes: One byte per clock while a frame is in flight
// Notes: Between frames data shows the inverse of the last byte, never a stale copy
`timescale 1ns/100ps
module rx_station (
   // Clock
   input wire logic i_core_clk,
   // Receive beats
   output wake_detect_pkg::rx_beat_t o_rx
);
   import wake_detect_pkg::*;
   initial o_rx = '0;
   // Plays one whole frame; crc state rides on the closing beat
   task automatic play(input logic [7:0] b[$], input logic bad);
      for (int i = 0; i < b.size(); i++) begin
         @(posedge i_core_clk);
         o_rx <= '{1'b1, i == 0, i == b.size() - 1, bad && i == b.size() - 1, b[i]};
      end
      @(posedge i_core_clk);
      o_rx <= '{1'b0, 1'b0, 1'b0, 1'b0, ~b[b.size() - 1]};
   endtask
endmodule

/* File: tb.sv */
// Purpose: Self-checking bench for the wake-frame detector
// Assumes: One AHB-Lite master and slave; 20 MHz core clock
// Notes: Read data and wake pulse lengths are judged from queues of notes
`timescale 1ns/100ps
module tb;
   import wake_detect_pkg::*;
   logic clk, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, pat_hit = 1'b0, pol_ev = 1'b0;
   logic rd_pend = 1'b0;
   logic [1:0] htrans = 2'b00;
   logic [31:0] haddr = '0, hwdata = '0, seed = 32'hdfda_5c30;
   wire hready, hresp, wake, int_ev;
   wire [31:0] hrdata;
   wire rx_beat_t rx;
   int error_cnt = 0, samples_checked = 0, wlen = 0;
   logic [31:0] rd_q[$];
   int wk_q[$];
   logic [15:0] val[6];
   logic [11:0] ix[6] = '{IDX_DA01, IDX_DA23, IDX_DA45, IDX_PW01, IDX_PW23, IDX_PW45};
   int wtab[4] = '{PULSE_CYC0, PULSE_CYC1, PULSE_CYC2, PULSE_CYC3};
   wake_detect dut (.i_core_clk(clk), .i_rst_b(rst_b), .i_clk_en(1'b1), .i_hsel(hsel),
      .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
      .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp),
      .o_hrdata(hrdata), .i_rx(rx), .i_pattern_hit(pat_hit), .i_pol_event(pol_ev),
      .o_wake(wake), .o_int_event(int_ev));
   rx_station src (.i_core_clk(clk), .o_rx(rx));
   // Free-running core clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic chk(input logic ok, input string msg);
      samples_checked++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   task automatic tally_and_finish();
      if (error_cnt == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Wire order as the far side must send it; each mode is its own inverse
   function automatic logic [7:0] ord(input logic [7:0] b, input logic [1:0] m);
      case (m)
         2'b01: return {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
         2'b10: return {b[3:0], b[7:4]};
         2'b11: return {b[4], b[5], b[6], b[7], b[0], b[1], b[2], b[3]};
         default: return b;
      endcase
   endfunction
   // One single transfer; the master waits on hready, never on a fixed count
   task automatic bus(input logic w, input logic [11:0] idx, input logic [15:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {18'h0_0000, idx, 2'b00};
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {16'h0000, d};
      do @(posedge clk); while (hready !== 1'b1);
   endtask
   task automatic rd(input logic [11:0] idx, input logic [15:0] e);
      rd_q.push_back({16'h0000, e});
      bus(1'b0, idx, 16'h0000);
   endtask
   // Delimiter, then sync run, address copies and optional password, or 20 pattern bytes; closing byte
   task automatic frame(input logic [7:0] sfd, input logic [1:0] m, input int pwk,
         input logic bad, input logic pat);
      logic [7:0] q[$];
      q.push_back(sfd);
      if (pat)
         repeat (20) q.push_back(8'(xs()) & 8'h7f);
      else begin
         repeat (SYNC_LEN) q.push_back(SYNC_BYTE);
         // Each copy is six bytes: even byte from the upper half, then the odd byte
         repeat (ADDR_COPIES) for (int k = 0; k < 3; k++) begin
            q.push_back(val[k][15:8]);
            q.push_back(val[k][7:0]);
         end
         for (int k = 0; k < 3 && pwk > 0; k++) begin
            q.push_back(val[k + 3][7:0] ^ {7'h00, pwk == 2});
            q.push_back(val[k + 3][15:8]);
         end
      end
      q.push_back(8'h00);
      foreach (q[i]) q[i] = ord(q[i], m);
      pat_hit <= pat;
      src.play(q, bad);
      pat_hit <= 1'b0;
   endtask
   task automatic scen(input logic [15:0] cfg, input logic [7:0] sfd, input int pwk,
         input logic bad, input logic pat, input int wk, input logic [15:0] st);
      bus(1'b1, IDX_CFG, cfg);
      if (wk != 0)
         wk_q.push_back(wk);
      frame(sfd, cfg[15:14], pwk, bad, pat);
      rd(IDX_STAT, st);
   endtask
   // Watcher: read data one edge after each accepted read, length of each wake
   always @(posedge clk) begin
      if (rd_pend === 1'b1 && rd_q.size() == 0)
         chk(1'b0, "unexpected read");
      else if (rd_pend === 1'b1)
         chk(hrdata === rd_q.pop_front() && hresp === 1'b0, "read data or response");
      rd_pend <= hsel & htrans[1] & hready & !hwrite;
      if (wake === 1'b1)
         wlen <= wlen + 1;
      else if (wlen > 0) begin
         if (wk_q.size() == 0)
            chk(1'b0, "unexpected wake");
         else if (wk_q[0] < 0)
            void'(wk_q.pop_front());
         else
            chk(wlen == wk_q.pop_front(), "wake pulse length");
         wlen <= 0;
      end
   end
   initial begin
      #2_000_000;
      chk(1'b0, "timeout");
      tally_and_finish();
   end
   initial begin
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      rd(IDX_CFG, CFG_RST);
      rd(IDX_STAT, 16'h0000);
      rd(12'h04AF, 16'h0000);
      for (int i = 0; i < 6; i++) begin
         rd(ix[i], 16'h0000);
         val[i] = 16'(xs()) & 16'h7f7f;
         bus(1'b1, ix[i], val[i]);
         rd(ix[i], val[i]);
      end
      frame(SFD_NORMAL, 2'b00, 0, 1'b0, 1'b0);
      rd(IDX_STAT, 16'h0000);
      bus(1'b1, IDX_CFG, 16'h1081);
      rd(IDX_STAT, 16'h1000);
      for (int m = 0; m < 4; m++) begin
         scen(16'h1081 | 16'(m << 14) | 16'(m << 9), SFD_NORMAL, 0, 0, 0, wtab[m], 16'h1001);
         rd(IDX_STAT, 16'h1000);
      end
      scen(16'h3081, SFD_NORMAL, 0, 0, 0, 0, 16'h1080);
      scen(16'h3081, SFD_ALT, 0, 0, 0, wtab[0], 16'h1001);
      scen(16'h1081, SFD_NORMAL, 0, 1, 0, 0, 16'h1040);
      scen(16'h0081, SFD_NORMAL, 0, 1, 0, wtab[0], 16'h1001);
      scen(16'h10A1, SFD_NORMAL, 1, 0, 0, wtab[0], 16'h1001);
      scen(16'h10A1, SFD_NORMAL, 2, 0, 0, 0, 16'h1020);
      scen(16'h1082, SFD_NORMAL, 0, 0, 1, wtab[0], 16'h1002);
      scen(16'h1080, SFD_NORMAL, 0, 0, 0, 0, 16'h1001);
      scen(16'h1181, SFD_NORMAL, 0, 0, 0, -1, 16'h1001);
      repeat (20) @(posedge clk);
      chk(wake === 1'b1, "wake level not held");
      bus(1'b1, IDX_CFG, 16'h1981);
      repeat (3) @(posedge clk);
      chk(wake === 1'b0, "wake level not cleared");
      rd(IDX_CFG, 16'h1181);
      bus(1'b1, IDX_STAT, 16'h0000);
      rd(IDX_STAT, 16'h0000);
      @(posedge clk);
      pol_ev <= 1'b1;
      @(posedge clk);
      pol_ev <= 1'b0;
      scen(16'h1001, SFD_NORMAL, 0, 0, 0, 0, 16'h0000);
      bus(1'b1, IDX_CFG, 16'h1081);
      rd(IDX_STAT, 16'h1000);
      repeat (5) @(posedge clk);
      chk(rd_q.size() == 0 && wk_q.size() == 0, "expected results never seen");
      tally_and_finish();
   end
endmodule
